/* File: shared/fmp_pkg.sv */
// Constants, register map and carrier types for the mark payload controller
package fmp_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_KEY    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_COMP   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TIME   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LOC    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STAT   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PAY_LO = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PAY_HI = 8'h18;

    localparam int KEY_IMG_BIT    = 0;
    localparam int KEY_AUD_BIT    = 1;
    localparam int COMP_START_BIT = 0;
    localparam int COMP_END_BIT   = 1;
    localparam int TIME_DAY_LSB   = 0;
    localparam int TIME_QH_LSB    = 16;
    localparam int STAT_ACT_BIT   = 0;
    localparam int STAT_IMG_BIT   = 1;
    localparam int STAT_AUD_BIT   = 2;
    localparam int STAT_KEY_BIT   = 3;
    localparam int STAT_TS_LSB    = 16;

    localparam int TS_W      = 16;
    localparam int LOC_W     = 19;
    localparam int PAY_W     = TS_W + LOC_W;
    localparam int DAY_W     = 9;
    localparam int QH_W      = 7;
    localparam int BIT_IDX_W = 6;
    localparam logic [BIT_IDX_W-1:0] PAY_LAST = 6'h22;

    localparam logic [DAY_W-1:0] DAYS_PER_YEAR = 9'h16E;
    localparam logic [QH_W-1:0]  QH_PER_DAY    = 7'h60;
    localparam logic [TS_W-1:0]  TS_COUNT      = 16'h8940;

    localparam int NS_PER_SEC     = 1000000000;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int SEC_CYCLES_DEF = NS_PER_SEC / CLK_PERIOD_NS;
    localparam int SEC_CNT_W      = 27;
    localparam int QH_SEC         = 900;
    localparam int SEG_SEC        = 300;
    localparam int SECS_W         = 10;

    typedef struct packed {
        logic valid;
        logic audio;
        logic encrypted;
    } fmp_ess_t;

    typedef struct packed {
        logic                 valid;
        logic                 audio;
        logic                 mark_on;
        logic                 mark_bit;
        logic [BIT_IDX_W-1:0] bit_idx;
    } fmp_mark_t;

    typedef struct packed {
        logic [LOC_W-1:0] loc;
        logic [TS_W-1:0]  ts;
    } fmp_payload_t;
endpackage

/* File: src/fmp_bit_seq.sv */
// Payload bit sequencer for one essence channel
`timescale 1ns/1ps
module fmp_bit_seq
    import fmp_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 restart,
    input  wire logic                 step,
    input  wire fmp_payload_t         payload,
    output logic [BIT_IDX_W-1:0]      idx,
    output logic                      bit_val
);
    logic [BIT_IDX_W-1:0] idx_reg;

    // Endless cycling gives many full copies per segment
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            idx_reg <= '0;
        end else if (step) begin
            idx_reg <= (idx_reg == PAY_LAST) ? '0 : idx_reg + 1'b1; // [R10] [R11]
        end
    end

    assign idx     = idx_reg;
    assign bit_val = payload[idx_reg];

    a_idx_wrap: assert property (@(posedge clk) disable iff (rst) // [R10]
        step && !restart && idx_reg == PAY_LAST |=> idx_reg == '0)
        else $error("bit index did not wrap after last payload bit");
    a_idx_bound: assert property (@(posedge clk) disable iff (rst) // [R6]
        idx_reg <= PAY_LAST)
        else $error("bit index beyond payload");
endmodule // fmp_bit_seq

/* File: src/fmp_mark_ctrl.sv */
// Forensic mark enable and payload controller with AHB-Lite registers
// Operation
// [R1] Never mark essence that arrived unencrypted.
// [R2] Decide marking per track file; plaintext tracks in mixed compositions stay unmarked.
// [R3] Image and audio suppression come separately from the key message.
// [R4] Suppression holds for the whole composition it was keyed for.
// [R5] New composition re-evaluates suppression from its own key, no carry-over.
// [R6] Payload is 35 bits holding timestamp and location.
// [R7] Timestamp steps each quarter hour over a 366-day year, then repeats.
// [R8] Timestamp field is exactly 16 bits.
// [R9] Location field is 19 bits.
// [R10] Every payload bit embedded at least once per five-minute segment.
// [R11] Payload repeated continuously so a 30-minute excerpt identifies.
// [R12] With both enabled, full payload goes into image and audio.
// [R13] Timestamp index is day times 96 plus quarter hour, yearly wrap.
// [R14] Payload latched at each segment start, constant within it.
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module fmp_mark_ctrl
    import fmp_pkg::*;
#(
    parameter int SEC_CYCLES = SEC_CYCLES_DEF
) (
    input  wire logic         CLK,
    input  wire logic         SYS_RST,
    input  wire logic         HSEL,
    input  wire logic [31:0]  HADDR,
    input  wire logic [1:0]   HTRANS,
    input  wire logic         HWRITE,
    input  wire logic [2:0]   HSIZE,
    input  wire logic [31:0]  HWDATA,
    input  wire logic         HREADY,
    output logic      [31:0]  HRDATA,
    output logic              HREADYOUT,
    output logic              HRESP,
    input  wire fmp_ess_t     ESS_IN,
    output fmp_mark_t         MARK_OUT
);
    logic [ADDR_W-1:0]    wr_addr_reg;
    logic                 wr_en_reg;
    logic [31:0]          hrdata_reg;
    logic                 hready_reg;
    logic                 hresp_reg;
    logic                 key_img_reg;
    logic                 key_aud_reg;
    logic                 key_valid_reg;
    logic                 sup_img_reg;
    logic                 sup_aud_reg;
    logic                 comp_act_reg;
    logic [DAY_W-1:0]     day_reg;
    logic [QH_W-1:0]      qh_reg;
    logic [TS_W-1:0]      ts_reg;
    logic [LOC_W-1:0]     loc_reg;
    logic [SEC_CNT_W-1:0] sec_cnt_reg;
    logic [SECS_W-1:0]    qh_sec_reg;
    logic [SECS_W-1:0]    seg_sec_reg;
    fmp_payload_t         payload_reg;
    fmp_mark_t            mark_reg;
    logic                 addr_phase;
    logic                 wr_key;
    logic                 wr_comp;
    logic                 wr_time;
    logic                 wr_loc;
    logic                 comp_start;
    logic                 comp_end;
    logic                 sec_tick;
    logic                 qh_tick;
    logic                 seg_tick;
    logic                 seg_start;
    logic                 img_en;
    logic                 aud_en;
    logic                 cur_mark;
    logic [1:0]           ch_bit;
    logic [BIT_IDX_W-1:0] ch_idx [2];
    logic [DAY_W-1:0]     wr_day;

    // Bus decode; zero-wait slave, data phase follows directly
    assign addr_phase = HSEL && HREADY && HTRANS[1];
    assign wr_key     = wr_en_reg && wr_addr_reg == OFS_KEY;
    assign wr_comp    = wr_en_reg && wr_addr_reg == OFS_COMP;
    assign wr_time    = wr_en_reg && wr_addr_reg == OFS_TIME;
    assign wr_loc     = wr_en_reg && wr_addr_reg == OFS_LOC;
    assign comp_start = wr_comp && HWDATA[COMP_START_BIT];
    assign comp_end   = wr_comp && HWDATA[COMP_END_BIT] && !HWDATA[COMP_START_BIT];
    assign wr_day     = HWDATA[TIME_DAY_LSB +: DAY_W];

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wr_en_reg   <= 1'b0;
            wr_addr_reg <= '0;
            hready_reg  <= 1'b1;
            hresp_reg   <= 1'b0;
        end else begin
            wr_en_reg   <= addr_phase && HWRITE;
            wr_addr_reg <= HADDR[ADDR_W-1:0];
        end
    end

    // Read data registered in the address phase; unmapped reads give zero
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            hrdata_reg <= '0;
        end else if (addr_phase && !HWRITE) begin
            unique case (HADDR[ADDR_W-1:0])
                OFS_KEY:    hrdata_reg <= {30'h0, key_aud_reg, key_img_reg};
                OFS_TIME:   hrdata_reg <= {9'h0, qh_reg, 7'h0, day_reg};
                OFS_LOC:    hrdata_reg <= {13'h0, loc_reg};
                OFS_STAT:   hrdata_reg <= {ts_reg, 12'h0, key_valid_reg, aud_en, img_en, comp_act_reg};
                OFS_PAY_LO: hrdata_reg <= payload_reg[31:0];
                OFS_PAY_HI: hrdata_reg <= {29'h0, payload_reg[PAY_W-1:32]};
                default:    hrdata_reg <= '0;
            endcase
        end
    end

    // Key flags wait here until a composition starts with them; a composition end drops them
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            key_img_reg   <= 1'b0;
            key_aud_reg   <= 1'b0;
            key_valid_reg <= 1'b0;
        end else if (wr_key) begin
            key_img_reg   <= HWDATA[KEY_IMG_BIT]; // [R3]
            key_aud_reg   <= HWDATA[KEY_AUD_BIT]; // [R3]
            key_valid_reg <= 1'b1;
        end else if (comp_start || comp_end) begin
            key_valid_reg <= 1'b0; // [R5]
        end
    end

    // Suppression frozen for the composition; a key write mid-play waits
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sup_img_reg  <= 1'b0;
            sup_aud_reg  <= 1'b0;
            comp_act_reg <= 1'b0;
        end else if (comp_start) begin
            sup_img_reg  <= key_valid_reg && key_img_reg; // [R5] [R3]
            sup_aud_reg  <= key_valid_reg && key_aud_reg; // [R5] [R3]
            comp_act_reg <= 1'b1; // [R4]
        end else if (comp_end) begin
            sup_img_reg  <= 1'b0; // [R5]
            sup_aud_reg  <= 1'b0; // [R5]
            comp_act_reg <= 1'b0;
        end
    end

    assign img_en = comp_act_reg && !sup_img_reg; // [R3] [R4]
    assign aud_en = comp_act_reg && !sup_aud_reg; // [R3] [R4]

    // Time base: seconds prescaler, quarter-hour and segment counters
    assign sec_tick = sec_cnt_reg == SEC_CNT_W'(SEC_CYCLES - 1);
    assign qh_tick  = sec_tick && qh_sec_reg == SECS_W'(QH_SEC - 1);
    assign seg_tick = sec_tick && seg_sec_reg == SECS_W'(SEG_SEC - 1);
    assign seg_start = seg_tick || comp_start;

    always_ff @(posedge CLK) begin
        if (SYS_RST || wr_time) begin
            sec_cnt_reg <= '0;
            qh_sec_reg  <= '0;
        end else if (sec_tick) begin
            sec_cnt_reg <= '0;
            qh_sec_reg  <= qh_tick ? '0 : qh_sec_reg + 1'b1;
        end else begin
            sec_cnt_reg <= sec_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST || comp_start) begin
            seg_sec_reg <= '0;
        end else if (sec_tick) begin
            seg_sec_reg <= seg_tick ? '0 : seg_sec_reg + 1'b1; // [R10]
        end
    end

    // Out-of-range day or quarter written by software falls back to zero
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            day_reg <= '0;
            qh_reg  <= '0;
        end else if (wr_time) begin
            day_reg <= (wr_day < DAYS_PER_YEAR) ? wr_day : '0;
            qh_reg  <= (HWDATA[TIME_QH_LSB +: QH_W] < QH_PER_DAY) ? HWDATA[TIME_QH_LSB +: QH_W] : '0;
        end else if (qh_tick) begin
            if (qh_reg == QH_PER_DAY - 1'b1) begin
                qh_reg  <= '0;
                day_reg <= (day_reg == DAYS_PER_YEAR - 1'b1) ? '0 : day_reg + 1'b1; // [R7] [R13]
            end else begin
                qh_reg <= qh_reg + 1'b1; // [R7]
            end
        end
    end

    // Product registered; timestamp lags the time registers by one cycle
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ts_reg <= '0;
        end else begin
            ts_reg <= TS_W'(day_reg) * TS_W'(QH_PER_DAY) + TS_W'(qh_reg); // [R13] [R8]
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            loc_reg <= '0;
        end else if (wr_loc) begin
            loc_reg <= HWDATA[LOC_W-1:0]; // [R9]
        end
    end

    // Latched per segment so a detector never sees two payloads mixed
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            payload_reg <= '0;
        end else if (seg_start) begin
            payload_reg <= '{loc: loc_reg, ts: ts_reg}; // [R14] [R6]
        end
    end

    // Per-track-file decision from the encryption flag of each unit
    assign cur_mark = ESS_IN.valid && ESS_IN.encrypted && (ESS_IN.audio ? aud_en : img_en); // [R1] [R2]

    // One sequencer per essence type; each keeps its own payload index
    generate
        for (genvar c = 0; c < 2; c++) begin : g_chan
            fmp_bit_seq u_seq (
                .clk     (CLK),
                .rst     (SYS_RST),
                .restart (seg_start),
                .step    (cur_mark && ESS_IN.audio == 1'(c)), // [R12]
                .payload (payload_reg),
                .idx     (ch_idx[c]),
                .bit_val (ch_bit[c])
            );
        end
    endgenerate

    // Index zeroed when idle so a detector never reads stray payload bits
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            mark_reg <= '0;
        end else begin
            mark_reg.valid    <= ESS_IN.valid;
            mark_reg.audio    <= ESS_IN.audio;
            mark_reg.mark_on  <= cur_mark; // [R1] [R2]
            mark_reg.mark_bit <= cur_mark && ch_bit[ESS_IN.audio]; // [R12]
            mark_reg.bit_idx  <= cur_mark ? ch_idx[ESS_IN.audio] : '0;
        end
    end

    assign HRDATA    = hrdata_reg;
    assign HREADYOUT = hready_reg;
    assign HRESP     = hresp_reg;
    assign MARK_OUT  = mark_reg;

    a_plain_unmarked: assert property (@(posedge CLK) disable iff (SYS_RST) // [R1]
        ESS_IN.valid && !ESS_IN.encrypted |=> MARK_OUT.valid && !MARK_OUT.mark_on)
        else $error("plaintext essence was marked");
    a_track_mark: assert property (@(posedge CLK) disable iff (SYS_RST) // [R2]
        ESS_IN.valid && ESS_IN.encrypted && !ESS_IN.audio && img_en |=> MARK_OUT.mark_on)
        else $error("encrypted image unit not marked");
    a_sup_split: assert property (@(posedge CLK) disable iff (SYS_RST) // [R3]
        ESS_IN.valid && ESS_IN.encrypted && ESS_IN.audio && comp_act_reg && !sup_aud_reg
        |=> MARK_OUT.mark_on == 1'b1)
        else $error("audio mark blocked by image suppression");
    a_sup_hold: assert property (@(posedge CLK) disable iff (SYS_RST) // [R4]
        comp_act_reg && !comp_start && !comp_end |=> $stable(sup_img_reg) && $stable(sup_aud_reg))
        else $error("suppression changed inside composition");
    a_no_carry: assert property (@(posedge CLK) disable iff (SYS_RST) // [R5]
        comp_start |=> sup_img_reg == ($past(key_valid_reg) && $past(key_img_reg))
                    && !key_valid_reg)
        else $error("suppression carried across compositions");
    a_pay_latch: assert property (@(posedge CLK) disable iff (SYS_RST) // [R14]
        seg_start |=> payload_reg == {$past(loc_reg), $past(ts_reg)})
        else $error("payload not latched at segment start");
    a_pay_steady: assert property (@(posedge CLK) disable iff (SYS_RST) // [R14]
        !seg_start |=> $stable(payload_reg))
        else $error("payload changed inside segment");
    a_ts_range: assert property (@(posedge CLK) disable iff (SYS_RST) // [R8]
        ts_reg < TS_COUNT)
        else $error("timestamp beyond yearly range");
    a_year_wrap: assert property (@(posedge CLK) disable iff (SYS_RST) // [R7]
        qh_tick && !wr_time && day_reg == DAYS_PER_YEAR - 1'b1 && qh_reg == QH_PER_DAY - 1'b1
        |=> day_reg == '0 && qh_reg == '0 ##1 ts_reg == '0)
        else $error("timestamp did not wrap at year end");
    a_seg_bound: assert property (@(posedge CLK) disable iff (SYS_RST) // [R10]
        seg_sec_reg < SECS_W'(SEG_SEC))
        else $error("segment longer than five minutes");
    a_bus_okay: assert property (@(posedge CLK) disable iff (SYS_RST)
        HREADYOUT && !HRESP)
        else $error("slave stalled or answered error");
    a_idle_index: assert property (@(posedge CLK) disable iff (SYS_RST) // [R1]
        ESS_IN.valid && !ESS_IN.encrypted |=> MARK_OUT.bit_idx == '0 && !MARK_OUT.mark_bit)
        else $error("unmarked unit carried payload bits");

    c_comp_start: cover property (@(posedge CLK) disable iff (SYS_RST) comp_start);
    c_img_mark: cover property (@(posedge CLK) disable iff (SYS_RST) MARK_OUT.mark_on && !MARK_OUT.audio);
    c_aud_mark: cover property (@(posedge CLK) disable iff (SYS_RST) MARK_OUT.mark_on && MARK_OUT.audio);
    c_seg_tick: cover property (@(posedge CLK) disable iff (SYS_RST) seg_tick && comp_act_reg);
    c_year_wrap: cover property (@(posedge CLK) disable iff (SYS_RST) qh_tick && ts_reg == TS_COUNT - 1'b1);
endmodule // fmp_mark_ctrl

/* File: verif/fmp_mark_detector.sv */
// Behavioural mark detector that rebuilds the payload from the marked stream
`timescale 1ns/1ps
module fmp_mark_detector
    import fmp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        clr,
    input  wire fmp_mark_t   mark,
    output logic [PAY_W-1:0] pay_img,
    output logic [PAY_W-1:0] pay_aud,
    output logic [PAY_W-1:0] seen_img,
    output logic [PAY_W-1:0] seen_aud,
    output int               cnt_img,
    output int               cnt_aud
);
    // Only marked units carry payload; unmarked units are ignored like a real detector
    always_ff @(posedge clk) begin
        if (clr) begin
            pay_img  <= '0;
            pay_aud  <= '0;
            seen_img <= '0;
            seen_aud <= '0;
            cnt_img  <= 0;
            cnt_aud  <= 0;
        end else if (mark.valid === 1'b1 && mark.mark_on === 1'b1) begin
            if (mark.audio) begin
                pay_aud[mark.bit_idx]  <= mark.mark_bit;
                seen_aud[mark.bit_idx] <= 1'b1;
                cnt_aud                <= cnt_aud + 1;
            end else begin
                pay_img[mark.bit_idx]  <= mark.mark_bit;
                seen_img[mark.bit_idx] <= 1'b1;
                cnt_img                <= cnt_img + 1;
            end
        end
    end
endmodule // fmp_mark_detector

/* File: verif/test_forensic_mark_payload_ctrl.sv */
// Self-checking bench for the mark payload controller
`timescale 1ns/1ps
module test_forensic_mark_payload_ctrl
    import fmp_pkg::*;
;
    // Short second keeps the quarter-hour wrap inside a few thousand cycles
    localparam int                SEC_CYC = 4;
    localparam logic [LOC_W-1:0]  LOC_A   = 19'h5A5A5;
    localparam logic [TS_W-1:0]   TS_A    = 16'(365 * 96 + 95);
    localparam logic [TS_W-1:0]   TS_B    = 16'(1 * 96 + 2);
    localparam logic [PAY_W-1:0]  PAY_A   = {LOC_A, TS_A};
    localparam logic [PAY_W-1:0]  PAY_B   = {LOC_A, TS_B};
    localparam logic [PAY_W-1:0]  ALL_ON  = '1;

    logic             clk     = 1'b0;
    logic             sys_rst = 1'b1;
    logic             hsel    = 1'b0;
    logic [31:0]      haddr   = '0;
    logic [1:0]       htrans  = '0;
    logic             hwrite  = 1'b0;
    logic [2:0]       hsize   = 3'h2;
    logic [31:0]      hwdata  = '0;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
    fmp_ess_t         ess     = '0;
    fmp_mark_t        mark;
    logic             det_clr = 1'b0;
    logic [PAY_W-1:0] pay_img;
    logic [PAY_W-1:0] pay_aud;
    logic [PAY_W-1:0] seen_img;
    logic [PAY_W-1:0] seen_aud;
    int               cnt_img;
    int               cnt_aud;
    int               n_errors = 0;
    int               samples_checked = 0;

    always #5 clk = ~clk;

    fmp_mark_ctrl #(.SEC_CYCLES(SEC_CYC)) i_fmp_mark_ctrl (
        .CLK(clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .ESS_IN(ess), .MARK_OUT(mark)
    );

    fmp_mark_detector i_fmp_mark_detector (
        .clk(clk), .clr(det_clr), .mark(mark), .pay_img(pay_img), .pay_aud(pay_aud),
        .seen_img(seen_img), .seen_aud(seen_aud), .cnt_img(cnt_img), .cnt_aud(cnt_aud)
    );

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic wait_ready();
        int t;
        t = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && t < 50) begin
            @(posedge clk);
            t++;
        end
    endtask

    // Single transfer; the leading edge leaves one idle cycle between transfers
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        check(40'({hreadyout, hresp}), 40'h2, "bus response");
    endtask

    task automatic det_clear();
        @(posedge clk);
        det_clr <= 1'b1;
        @(posedge clk);
        det_clr <= 1'b0;
    endtask

    task automatic send(input logic aud, input logic enc, input int n);
        repeat (n) begin
            @(posedge clk);
            ess <= '{valid: 1'b1, audio: aud, encrypted: enc};
        end
        @(posedge clk);
        ess <= '0;
        repeat (2) @(posedge clk);
    endtask

    task automatic counts(input int ei, input int ea, input string what);
        check(40'(cnt_img), 40'(ei), what);
        check(40'(cnt_aud), 40'(ea), what);
    endtask

    task automatic t_reset();
        logic [31:0] q;
        bus(1'b0, OFS_STAT, '0, q);
        check(40'(q), '0, "status after reset");
        bus(1'b0, OFS_PAY_LO, '0, q);
        check(40'(q), '0, "payload after reset");
        bus(1'b1, 8'h40, 32'hFFFF_FFFF, q);
        bus(1'b0, 8'h40, '0, q);
        check(40'(q), '0, "unmapped read");
        det_clear();
        send(1'b0, 1'b1, 5);
        send(1'b1, 1'b1, 5);
        counts(0, 0, "marks without composition");
        $display("test reset done");
    endtask

    task automatic t_encrypt();
        logic [31:0] q;
        bus(1'b1, OFS_KEY, '0, q);
        bus(1'b1, OFS_COMP, 32'h1, q);
        det_clear();
        send(1'b0, 1'b1, 8);
        send(1'b0, 1'b0, 8);
        send(1'b1, 1'b0, 8);
        send(1'b1, 1'b1, 8);
        counts(8, 8, "mixed track files");
        bus(1'b1, OFS_COMP, 32'h2, q);
        $display("test encrypt done");
    endtask

    // Every suppress code, then a rival key mid-composition that must wait
    task automatic t_suppress();
        logic [31:0] q;
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, OFS_KEY, 32'(k), q);
            bus(1'b1, OFS_COMP, 32'h1, q);
            det_clear();
            send(1'b0, 1'b1, 6);
            send(1'b1, 1'b1, 6);
            counts(k[0] ? 0 : 6, k[1] ? 0 : 6, "suppress per type");
            bus(1'b1, OFS_KEY, 32'(3 - k), q);
            bus(1'b0, OFS_STAT, '0, q);
            check(40'(q[3:0]), 40'({1'b1, !k[1], !k[0], 1'b1}), "status held");
            det_clear();
            send(1'b0, 1'b1, 6);
            send(1'b1, 1'b1, 6);
            counts(k[0] ? 0 : 6, k[1] ? 0 : 6, "suppress held");
            bus(1'b1, OFS_COMP, 32'h2, q);
        end
        bus(1'b1, OFS_COMP, 32'h1, q);
        det_clear();
        send(1'b0, 1'b1, 6);
        send(1'b1, 1'b1, 6);
        counts(6, 6, "no carry-over");
        bus(1'b1, OFS_COMP, 32'h2, q);
        $display("test suppress done");
    endtask

    task automatic t_payload();
        logic [31:0] q;
        bus(1'b1, OFS_TIME, 32'h005F_016D, q);
        bus(1'b1, OFS_LOC, 32'(LOC_A), q);
        bus(1'b0, OFS_LOC, '0, q);
        check(40'(q), 40'(LOC_A), "location readback");
        bus(1'b0, OFS_STAT, '0, q);
        check(40'(q[31:16]), 40'(TS_A), "timestamp index");
        bus(1'b1, OFS_COMP, 32'h1, q);
        bus(1'b0, OFS_PAY_LO, '0, q);
        check(40'(q), 40'(PAY_A[31:0]), "payload low");
        bus(1'b0, OFS_PAY_HI, '0, q);
        check(40'(q), 40'(PAY_A[34:32]), "payload high");
        det_clear();
        send(1'b0, 1'b1, 35);
        send(1'b1, 1'b1, 35);
        check(40'(pay_img), 40'(PAY_A), "image payload");
        check(40'(seen_img), 40'(ALL_ON), "image bits seen");
        check(40'(pay_aud), 40'(PAY_A), "audio payload");
        check(40'(seen_aud), 40'(ALL_ON), "audio bits seen");
        $display("test payload done");
    endtask

    // New time mid-segment must not leak into the payload until the next segment
    task automatic t_segment();
        logic [31:0] q;
        bus(1'b1, OFS_COMP, 32'h2, q);
        bus(1'b1, OFS_COMP, 32'h1, q);
        bus(1'b1, OFS_TIME, 32'h0002_0001, q);
        bus(1'b0, OFS_TIME, '0, q);
        check(40'(q), 40'h2_0001, "time readback");
        bus(1'b0, OFS_PAY_LO, '0, q);
        check(40'(q), 40'(PAY_A[31:0]), "payload held in segment");
        repeat (1210) @(posedge clk);
        bus(1'b0, OFS_PAY_LO, '0, q);
        check(40'(q), 40'(PAY_B[31:0]), "payload at next segment");
        det_clear();
        send(1'b0, 1'b1, 35);
        check(40'(pay_img), 40'(PAY_B), "new segment payload");
        check(40'(seen_img), 40'(ALL_ON), "new segment bits seen");
        $display("test segment done");
    endtask

    task automatic t_wrap();
        logic [31:0] q;
        bus(1'b1, OFS_TIME, 32'h005F_016D, q);
        repeat (3580) @(posedge clk);
        bus(1'b0, OFS_STAT, '0, q);
        check(40'(q[31:16]), 40'(TS_A), "last quarter of year");
        repeat (30) @(posedge clk);
        bus(1'b0, OFS_STAT, '0, q);
        check(40'(q[31:16]), '0, "yearly wrap");
        // Day beyond the year and quarter beyond the day each fall back to zero
        bus(1'b1, OFS_TIME, 32'h0003_016E, q);
        bus(1'b0, OFS_TIME, '0, q);
        check(40'(q), 40'h3_0000, "day out of range");
        bus(1'b1, OFS_TIME, 32'h0060_0005, q);
        bus(1'b0, OFS_TIME, '0, q);
        check(40'(q), 40'h5, "quarter out of range");
        $display("test wrap done");
    endtask

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_encrypt();
        t_suppress();
        t_payload();
        t_segment();
        t_wrap();
        close_out();
    end

    // Tests need about 5300 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        close_out();
    end
endmodule // test_forensic_mark_payload_ctrl
